// file: hw/hsf_cfg.svh
// Constants for the head select, mode and unsafe fault block.
// Assumes a 200 MHz pclk and an APB slave with 32-bit words.
`ifndef HSF_CFG_SVH
`define HSF_CFG_SVH

// ==========================================================================
// Timing
`define HSF_CLK_PS 5000
`define HSF_PULSE_NS 25
`define HSF_PULSE_CYC ((`HSF_PULSE_NS * 1000) / `HSF_CLK_PS)
`define HSF_CELL_NS 200
`define HSF_NODATA_CELLS 4
`define HSF_NODATA_CYC \
   ((`HSF_CELL_NS * `HSF_NODATA_CELLS * 1000 + `HSF_CLK_PS - 1) / `HSF_CLK_PS)

// ==========================================================================
// Head codes
`define HSF_NUM_HEADS 5
`define HSF_MAX_HEAD 3'h4

// ==========================================================================
// Register offsets (byte addresses)
`define HSF_OFF_CTRL 12'h000
`define HSF_OFF_STATUS 12'h004
`define HSF_OFF_IRQ_STAT 12'h008
`define HSF_OFF_IRQ_EN 12'h00c
`define HSF_OFF_IRQ_CLR 12'h010

// ==========================================================================
// Field positions and reset values
`define HSF_CTRL_FAULT_CLR 0
`define HSF_CTRL_WR_PERMIT 1
`define HSF_CTRL_RESET 32'h0000_0002
`define HSF_IRQ_FAULT 0
`define HSF_IRQ_NODATA 1
`define HSF_IRQ_BADHEAD 2
`define HSF_IRQ_W 3

`endif

// file: hw/hsf_pkg.sv
// Types shared by the head select, mode and unsafe fault block.
// Assumes hsf_cfg.svh is included first.
`include "hsf_cfg.svh"

package hsf_pkg;

   // =======================================================================
   // Pins from the cable, the preamp and the read comparators.
   typedef struct packed {
      logic head_code_bit2;
      logic head_code_bit1;
      logic head_code_bit0;
      logic write_select_n;
      logic hi_res;
      logic lo_res;
      logic write_data;
      logic head_short;
      logic head_open;
      logic wc_sense;
   } hsf_pins_t;

   // Pins driven towards the heads, the preamp and the cable.
   typedef struct packed {
      logic [`HSF_NUM_HEADS-1:0] head_sel;
      logic write_mode;
      logic write_current_sink;
      logic write_enable;
      logic clamp;
      logic unsafe_n;
      logic read_data_p;
      logic read_data_n;
   } hsf_drive_t;

   // Operating mode, one-hot.
   typedef enum logic [2:0] {
      ST_READ = 3'b001,
      ST_WRITE = 3'b010,
      ST_FAULT = 3'b100
   } hsf_state_t;

endpackage : hsf_pkg

// file: hw/hsf_top.sv
// Head select decode, read/write mode, unsafe fault latch and read pulse
// qualifier, with an APB register slave and one level interrupt.
// Assumes all pin inputs are asynchronous to pclk; APB is on pclk.
//
// Operation
// - Head code values zero to four select exactly one of five heads.
// - Head numbers count surfaces upward from the bottom of the stack.
// - Head code pins are active low: low level means logical one.
// - In read mode, codes five to seven deselect every head.
// - Unsafe on write with invalid head or with no write transitions.
// - Unsafe on shorted head, open head, or write current in read.
// - Write mode while write select is low, else read mode.
// - Unsafe output goes from high to low when unsafe.
// - Active unsafe sets the write fault latch.
// - In read mode the selected head feeds the read data pair.
// - High resolution edges clock two flops enabled by low resolution.
// - The two qualified flops are ORed into one pulse per transition.
// - Each pulse is stretched to 25 ns, driven as a balanced pair.
// - Read clamp is asserted throughout write mode.
// - Set latch inhibits write mode, current and enable until software clears it.
// - Bit cell is 200 ns nominal, five megabits per second.
`timescale 1ns/1ps
`default_nettype none
`include "hsf_cfg.svh"

module hsf_top #(
   parameter int NODATA_CYC = `HSF_NODATA_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire hsf_pkg::hsf_pins_t pins,
   output hsf_pkg::hsf_drive_t drive,
   output logic irq
);
   import hsf_pkg::*;

   localparam int NPIN = $bits(hsf_pins_t);
   localparam logic [2:0] PULSE_CYC = 3'(`HSF_PULSE_CYC);
   localparam logic [15:0] NODATA_LIM = 16'(NODATA_CYC);
   // Idle pin levels are head code zero and write select off. The chains
   // reset to these, so no false write request or bad head follows reset.
   localparam hsf_pins_t PIN_IDLE = '{head_code_bit2: 1'b1,
      head_code_bit1: 1'b1, head_code_bit0: 1'b1, write_select_n: 1'b1,
      default: 1'b0};
   localparam logic [NPIN-1:0] IDLE_VEC = PIN_IDLE;

   // ========================================================================
   // Pin synchronisers
   // Four flops per pin; a new level is accepted only when the second and
   // third agree, which keeps a metastable first stage out of the logic.
   logic [NPIN-1:0] pin_vec;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] stab_q;
   hsf_pins_t sp;

   assign pin_vec = pins;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         // Each pin runs its own chain and stable level.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_q[gi] <= IDLE_VEC[gi];
               s2_q[gi] <= IDLE_VEC[gi];
               s3_q[gi] <= IDLE_VEC[gi];
               stab_q[gi] <= IDLE_VEC[gi];
            end else if (ce) begin
               s1_q[gi] <= pin_vec[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) begin
                  stab_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   assign sp = stab_q;

   // ========================================================================
   // Head decode
   // Pins are active low, so the code is the inverse of the levels.
   wire [2:0] head_code = ~{sp.head_code_bit2, sp.head_code_bit1,
                            sp.head_code_bit0};
   wire head_valid = (head_code <= `HSF_MAX_HEAD);
   // Head zero is the lowest surface; numbers rise up the stack.
   wire [`HSF_NUM_HEADS-1:0] head_onehot =
      head_valid ? `HSF_NUM_HEADS'(1) << head_code : '0;

   // ========================================================================
   // Registers and mode
   hsf_state_t st_q;
   hsf_state_t st_d;
   logic [31:0] ctrl_q;
   logic [`HSF_IRQ_W-1:0] irq_stat_q;
   logic [`HSF_IRQ_W-1:0] irq_en_q;
   logic [15:0] nodata_q;
   logic wd_prev_q;
   logic unsafe_q;
   logic hr_prev_q;
   logic qual_rise_q;
   logic qual_fall_q;
   logic [2:0] stretch_q;
   hsf_drive_t drive_q;

   wire wr_req = !sp.write_select_n;
   wire in_write = (st_q == ST_WRITE);
   wire faulted = (st_q == ST_FAULT);
   wire wd_edge = sp.write_data ^ wd_prev_q;
   wire nodata = in_write && (nodata_q >= NODATA_LIM);
   wire bad_head_wr = wr_req && !head_valid;

   // Unsafe sources, all on synchronised levels.
   wire unsafe_c = bad_head_wr || nodata || sp.head_short ||
                   sp.head_open || (!in_write && sp.wc_sense);

   // APB decode; the slave never waits.
   wire acc = psel && penable;
   wire wr_acc = acc && pwrite;
   wire hit_ctrl = (paddr == `HSF_OFF_CTRL);
   wire hit_stat = (paddr == `HSF_OFF_STATUS);
   wire hit_istat = (paddr == `HSF_OFF_IRQ_STAT);
   wire hit_ien = (paddr == `HSF_OFF_IRQ_EN);
   wire hit_iclr = (paddr == `HSF_OFF_IRQ_CLR);
   wire hit_any = hit_ctrl | hit_stat | hit_istat | hit_ien | hit_iclr;
   wire fault_clr = wr_acc && hit_ctrl && pwdata[`HSF_CTRL_FAULT_CLR];
   wire wr_permit = ctrl_q[`HSF_CTRL_WR_PERMIT];
   wire [`HSF_IRQ_W-1:0] irq_clr =
      (wr_acc && hit_iclr) ? pwdata[`HSF_IRQ_W-1:0] : '0;
   wire [`HSF_IRQ_W-1:0] irq_set = {bad_head_wr, nodata,
                                    unsafe_q && !faulted};
   wire [31:0] status_word = {24'h0, head_code, st_q, !drive_q.unsafe_n,
                              faulted};

   assign pready = 1'b1;
   assign pslverr = acc && !hit_any;
   assign prdata = (!psel || pwrite) ? 32'h0 :
                   hit_ctrl ? ctrl_q :
                   hit_stat ? status_word :
                   hit_istat ? 32'(irq_stat_q) :
                   hit_ien ? 32'(irq_en_q) : 32'h0;
   assign irq = |(irq_stat_q & irq_en_q);

   // Mode machine. The latch holds until software clears it; a clear that
   // meets a live unsafe loses, so the latch cannot be bypassed.
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_READ: begin
            if (unsafe_q) begin
               st_d = ST_FAULT;
            end else if (wr_req && wr_permit) begin
               st_d = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (unsafe_q) begin
               st_d = ST_FAULT;
            end else if (!wr_req || !wr_permit) begin
               st_d = ST_READ;
            end
         end
         ST_FAULT: begin
            if (fault_clr && !unsafe_q) begin
               st_d = ST_READ;
            end
         end
         default: begin
            st_d = ST_FAULT;
         end
      endcase
   end

   // State, registers and the write transition watchdog.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_READ;
         ctrl_q <= `HSF_CTRL_RESET;
         irq_stat_q <= '0;
         irq_en_q <= '0;
         nodata_q <= '0;
         wd_prev_q <= 1'b0;
         unsafe_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         unsafe_q <= unsafe_c;
         wd_prev_q <= sp.write_data;
         nodata_q <= (!in_write || wd_edge) ? '0 :
                     nodata_q + ((nodata_q < NODATA_LIM) ? 16'h1 : 16'h0);
         if (wr_acc && hit_ctrl) begin
            ctrl_q <= {30'h0, pwdata[`HSF_CTRL_WR_PERMIT], 1'b0};
         end
         if (wr_acc && hit_ien) begin
            irq_en_q <= pwdata[`HSF_IRQ_W-1:0];
         end
         // A set in the same cycle as a clear wins.
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end

   // ========================================================================
   // Read pulse qualifier
   // Both flops sample on a high resolution edge, each enabled by the low
   // resolution level of matching polarity, so noise edges drop out.
   wire hr_rise = sp.hi_res && !hr_prev_q;
   wire hr_fall = !sp.hi_res && hr_prev_q;
   wire qual_pulse = qual_rise_q || qual_fall_q;
   wire stretch_busy = (stretch_q != 3'h0);

   // The stretcher does not retrigger, like a one-shot.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hr_prev_q <= 1'b0;
         qual_rise_q <= 1'b0;
         qual_fall_q <= 1'b0;
         stretch_q <= 3'h0;
      end else if (ce) begin
         hr_prev_q <= sp.hi_res;
         qual_rise_q <= hr_rise && sp.lo_res;
         qual_fall_q <= hr_fall && !sp.lo_res;
         if (stretch_busy) begin
            stretch_q <= stretch_q - 3'h1;
         end else if (qual_pulse && !in_write) begin
            stretch_q <= PULSE_CYC;
         end
      end
   end

   // ========================================================================
   // Drive outputs
   // Write controls are gated by the state, so a set latch forces them off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_q <= '{head_sel: '0, unsafe_n: 1'b1, read_data_n: 1'b1,
                      default: 1'b0};
      end else if (ce) begin
         drive_q.head_sel <= head_onehot;
         drive_q.write_mode <= in_write;
         drive_q.write_current_sink <= in_write && head_valid;
         drive_q.write_enable <= in_write;
         drive_q.clamp <= in_write || wr_req;
         drive_q.unsafe_n <= !unsafe_c;
         drive_q.read_data_p <= stretch_busy;
         drive_q.read_data_n <= !stretch_busy;
      end
   end

   assign drive = drive_q;

   // ========================================================================
   // Checks

   a_head_decode: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      head_valid |=> drive.head_sel == $past(head_onehot) &&
                     $onehot(drive.head_sel))
      else $error("head select not one-hot for a valid code");

   a_invalid_deselect: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      (!in_write && head_code > `HSF_MAX_HEAD) |=> drive.head_sel == '0)
      else $error("invalid code left a head selected");

   a_unsafe_low: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      unsafe_c |=> !drive.unsafe_n)
      else $error("unsafe output not low after unsafe cause");

   a_fault_sets: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      unsafe_q |=> st_q == ST_FAULT)
      else $error("unsafe did not set the fault latch");

   a_fault_inhibit: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      faulted ##1 faulted |-> !drive.write_enable &&
                              !drive.write_current_sink && !drive.write_mode)
      else $error("write path active while faulted");

   a_clamp_write: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      drive.write_mode |-> drive.clamp)
      else $error("clamp off during write mode");

   a_pulse_width: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      $rose(drive.read_data_p) |-> drive.read_data_p[*5] ##1
         (!drive.read_data_p && drive.read_data_n))
      else $error("read pulse not five cycles wide");

   a_write_entry: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      (st_q == ST_READ && wr_req && wr_permit && !unsafe_q) |=> in_write
         ##1 drive.write_mode)
      else $error("write select did not enter write mode");

   a_nodata_unsafe: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      nodata |=> !drive.unsafe_n ##1 faulted)
      else $error("missing write data did not raise unsafe");

endmodule : hsf_top
`default_nettype wire

// file: tb/hsf_ctl_model.sv
// Model of the controller side of the cable and of the read comparators.
// Assumes the bench commands it at pclk rising edges; levels are held.
`timescale 1ns/1ps
`default_nettype none

module hsf_ctl_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] head,
   input wire logic wr_on,
   input wire logic data_on,
   input wire logic flux,
   input wire logic flux_ok,
   input wire logic [2:0] senses,
   output var hsf_pkg::hsf_pins_t pins
);
   import hsf_pkg::*;
   // =====================================================================
   // One 200 ns bit cell at 5 ns per clock.
   localparam int CELL_CYC = 40;
   logic [2:0] code_q;
   logic [3:0] settle_q;
   logic [5:0] cell_q;
   logic wsel_n_q, wdata_q, hi_q, lo_q;

   // Write select waits until the head code has been steady for a while,
   // so the device never writes on a head that is still changing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= 3'h0;
         settle_q <= 4'h0;
         cell_q <= 6'h00;
         wsel_n_q <= 1'b1;
         wdata_q <= 1'b0;
         hi_q <= 1'b0;
         lo_q <= 1'b0;
      end else begin
         code_q <= head;
         settle_q <= (head != code_q) ? 4'h0 : settle_q + {3'h0, ~&settle_q};
         wsel_n_q <= !(wr_on && settle_q >= 4'h8);
         // One transition each cell while writing; stands still otherwise.
         if (wr_on && data_on) begin
            cell_q <= (cell_q == 6'(CELL_CYC - 1)) ? 6'h00 : cell_q + 6'h01;
            if (cell_q == 6'(CELL_CYC - 1)) begin
               wdata_q <= ~wdata_q;
            end
         end
         // A true transition moves both comparators, a false one only hi.
         if (flux) begin
            hi_q <= ~hi_q;
            if (flux_ok) begin
               lo_q <= ~hi_q;
            end
         end
      end
   end

   // Head code goes out active low on the cable.
   assign pins = '{head_code_bit2: ~code_q[2], head_code_bit1: ~code_q[1],
      head_code_bit0: ~code_q[0], write_select_n: wsel_n_q, hi_res: hi_q,
      lo_res: lo_q, write_data: wdata_q, head_short: senses[0],
      head_open: senses[1], wc_sense: senses[2]};

endmodule : hsf_ctl_model
`default_nettype wire

// file: tb/hsf_top_tb_top.sv
// Self-checking bench for the head select, mode and unsafe fault block.
// Assumes the controller model file and a 200 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
`include "hsf_cfg.svh"

module hsf_top_tb_top;
   import hsf_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, err;
   logic [2:0] head = 3'h0, senses = 3'h0;
   logic wr_on = 1'b0, data_on = 1'b0, flux = 1'b0, flux_ok = 1'b0;
   hsf_pins_t pins;
   hsf_drive_t drv;
   int n_errors = 0, n_checks = 0, i, len;

   // A short no-data limit keeps the fault scenarios brief.
   hsf_top #(.NODATA_CYC(64)) dut (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .drive(drv), .irq(irq));
   hsf_ctl_model ctl (.pclk(pclk), .presetn(presetn), .head(head),
      .wr_on(wr_on), .data_on(data_on), .flux(flux), .flux_ok(flux_ok),
      .senses(senses), .pins(pins));

   // =====================================================================
   // Clock, comparison and closing.
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk("apb_wait", 32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic clear_fault;
      apb(`HSF_OFF_CTRL, 1'b1, 32'h3);
      apb(`HSF_OFF_IRQ_CLR, 1'b1, 32'h7);
   endtask : clear_fault
   // Waits a bounded time for the unsafe output to go low.
   task automatic expect_unsafe(input string what);
      int n;
      for (n = 0; n < 150 && drv.unsafe_n !== 1'b0; n++) cyc(1);
      chk(what, {31'h0, drv.unsafe_n}, 32'h0);
   endtask : expect_unsafe
   // One flux transition, then count read pulse cycles and pair balance.
   task automatic pulse(input logic ok);
      int n;
      len = 0;
      @(posedge pclk);
      flux <= 1'b1;
      flux_ok <= ok;
      @(posedge pclk);
      flux <= 1'b0;
      for (n = 0; n < 30; n++) begin
         @(posedge pclk);
         len += int'(drv.read_data_p === 1'b1);
         if (drv.read_data_n !== ~drv.read_data_p) len += 100;
      end
      chk("rd_pulse", 32'(len), ok ? 32'h5 : 32'h0);
   endtask : pulse

   // =====================================================================
   // Main sequence.
   initial begin
      cyc(3);
      presetn <= 1'b1;
      chk("unsafe_rst", {31'h0, drv.unsafe_n}, 32'h1);
      apb(`HSF_OFF_CTRL, 1'b0, 32'h0);
      chk("ctrl_rst", rd, `HSF_CTRL_RESET);
      apb(12'h020, 1'b0, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      apb(`HSF_OFF_IRQ_EN, 1'b1, 32'h1);
      for (i = 0; i < 8; i++) begin
         head <= i[2:0];
         cyc(10);
         chk("head_sel", {27'h0, drv.head_sel},
            (i < 5) ? 32'h1 << i : 32'h0);
      end
      head <= 3'h1;
      pulse(1'b1);
      pulse(1'b0);
      pulse(1'b1);
      // A true falling transition goes through the other qualified flop.
      pulse(1'b1);
      head <= 3'h2;
      wr_on <= 1'b1;
      data_on <= 1'b1;
      cyc(30);
      chk("wr_outs", {28'h0, drv.write_mode, drv.write_enable,
         drv.write_current_sink, drv.clamp}, 32'hf);
      cyc(200);
      chk("wr_safe", {31'h0, drv.unsafe_n}, 32'h1);
      data_on <= 1'b0;
      expect_unsafe("nodata");
      cyc(60);
      chk("inhibit", {29'h0, drv.write_mode, drv.write_enable,
         drv.write_current_sink}, 32'h0);
      chk("irq_on", {31'h0, irq}, 32'h1);
      apb(`HSF_OFF_IRQ_STAT, 1'b0, 32'h0);
      chk("irq_stat", rd, 32'h3);
      apb(`HSF_OFF_IRQ_EN, 1'b1, 32'h0);
      cyc(1);
      chk("irq_mask", {31'h0, irq}, 32'h0);
      apb(`HSF_OFF_IRQ_EN, 1'b1, 32'h1);
      wr_on <= 1'b0;
      cyc(10);
      clear_fault;
      cyc(2);
      chk("irq_off", {31'h0, irq}, 32'h0);
      apb(`HSF_OFF_STATUS, 1'b0, 32'h0);
      chk("status", {27'h0, rd[4:0]}, 32'h4);
      head <= 3'h5;
      wr_on <= 1'b1;
      expect_unsafe("badhead");
      chk("bad_sel", {27'h0, drv.head_sel}, 32'h0);
      apb(`HSF_OFF_IRQ_STAT, 1'b0, 32'h0);
      chk("bad_stat", rd, 32'h5);
      wr_on <= 1'b0;
      head <= 3'h0;
      cyc(10);
      clear_fault;
      for (i = 0; i < 3; i++) begin
         senses <= 3'h1 << i;
         expect_unsafe("sense");
         senses <= 3'h0;
         cyc(10);
         clear_fault;
         cyc(2);
         chk("cleared", {31'h0, drv.unsafe_n, irq}, 32'h2);
      end
      // A write while the clock enable is low must be lost.
      ce <= 1'b0;
      apb(`HSF_OFF_IRQ_EN, 1'b1, 32'h0);
      ce <= 1'b1;
      apb(`HSF_OFF_IRQ_EN, 1'b0, 32'h0);
      chk("ce_hold", rd, 32'h1);
      stop_test;
   end

   // The whole run takes under a thousand cycles; this cuts a hang short.
   initial begin
      #100000;
      n_errors++;
      stop_test;
   end

endmodule : hsf_top_tb_top
`default_nettype wire
